// ==== ufspi_slave.v ====
`timescale 1ns/1ps
`include "ufspi_defines.vh"

module ufspi_slave (
	input  wire        i_mclk,       // 250 MHz system clock
	input  wire        i_rst_n,      // async reset, active low
	input  wire        i_sck,        // serial clock from master
	input  wire        i_chip_select_n, // chip select, active low
	input  wire        i_si,         // serial data in
	input  wire        i_ext_mode,   // 1 extended, 0 base mode
	input  wire [15:0] i_rd_data,    // flash read word
	input  wire        i_rd_valid,   // flash read word valid
	input  wire        i_fl_ready,   // flash accepts command
	input  wire        i_fl_busy,    // flash cycle in progress
	output reg         o_so,         // serial data out
	output reg         o_so_oe,      // serial out enable
	output reg         o_oscillator_enable, // flash oscillator on
	output reg         o_rd_req,     // flash read request pulse
	output reg  [8:0]  o_rd_addr,    // flash read address
	output reg         o_fl_valid,   // flash command valid
	output reg  [1:0]  o_fl_cmd,     // flash command code
	output reg  [8:0]  o_fl_addr,    // flash command address
	output reg  [15:0] o_fl_data     // flash write data
);

localparam [2:0] ST_IDLE   = 3'h0;
localparam [2:0] ST_OP     = 3'h1;
localparam [2:0] ST_ADDR   = 3'h2;
localparam [2:0] ST_WDATA  = 3'h3;
localparam [2:0] ST_RDATA  = 3'h4;
localparam [2:0] ST_STRD   = 3'h5;
localparam [2:0] ST_STWR   = 3'h6;
localparam [2:0] ST_IGNORE = 3'h7;

// true when the protection level covers this address
function prot_hit;
	input [1:0] lvl;
	input [8:0] a;
	input       ext;
	reg   [1:0] top;
	begin
		top = ext ? a[8:7] : a[7:6];
		prot_hit = (lvl == 2'h3) | ((lvl == 2'h2) & top[1]) |
			((lvl == 2'h1) & (top == 2'h3));
	end
endfunction

reg         sck_m, sck_s, sck_d;
reg         cs_m, cs_s, cs_d;
reg         si_m, si_s, ext_m, ext_s;

reg  [2:0]  state;
reg  [4:0]  cnt, ocnt;
reg  [15:0] rin, sh, rd_word, pend_data, sk_data;
reg  [8:0]  addr, pend_addr, sk_addr;
reg  [7:0]  op;
reg         ext, base_end, wen, sk_v;
reg  [1:0]  prot, pend_cmd, sk_cmd;

wire        sck_rise = sck_s & ~sck_d;
wire        sck_fall = ~sck_s & sck_d;
wire        cs_fall  = ~cs_s & cs_d;
wire        cs_rise  = cs_s & ~cs_d;
wire [15:0] word_in  = {rin[14:0], si_s};
wire [4:0]  next_cnt = cnt + 5'h01;
wire [4:0]  dw       = ext ? `UFSPI_EXT_W : `UFSPI_BASE_W;
wire [4:0]  fw       = (state == ST_OP || state == ST_STWR) ?
	`UFSPI_BYTE_W : dw;
wire        busy     = o_fl_valid | sk_v | i_fl_busy;
wire [7:0]  status   = {4'h0, prot, wen, busy};
wire [8:0]  addr_in  = ext ? word_in[8:0] : {1'b0, word_in[7:0]};
wire [15:0] rd_al    = ext ? rd_word : {rd_word[7:0], 8'h00};
wire [8:0]  addr_inc = (addr + 9'h001) & `UFSPI_EXT_ADDR_MASK;
wire        fl_pop   = o_fl_valid & i_fl_ready;
wire        wr_ok    = wen & ~prot_hit(prot, pend_addr, ext);
wire        er_ok    = wen & (prot == 2'h0);
wire        push     = cs_rise & ~sk_v & (pend_cmd != `UFSPI_CMD_NONE) &
	((pend_cmd == `UFSPI_CMD_WRITE) ? wr_ok : er_ok);

// pins cross from the master clock domain; first stage feeds only second
always @(posedge i_mclk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		sck_m <= 1'b0;
		sck_s <= 1'b0;
		sck_d <= 1'b0;
		cs_m  <= 1'b1;
		cs_s  <= 1'b1;
		cs_d  <= 1'b1;
		si_m  <= 1'b0;
		si_s  <= 1'b0;
		ext_m <= 1'b0;
		ext_s <= 1'b0;
	end else begin
		sck_m <= i_sck;
		sck_s <= sck_m;
		sck_d <= sck_s;
		cs_m  <= i_chip_select_n;
		cs_s  <= cs_m;
		cs_d  <= cs_s;
		si_m  <= i_si;
		si_s  <= si_m;
		ext_m <= i_ext_mode;
		ext_s <= ext_m;
	end
end

always @(posedge i_mclk or negedge i_rst_n) begin
	if (!i_rst_n)
		o_oscillator_enable <= 1'b1;
	else
		o_oscillator_enable <= 1'b1;
end

always @(posedge i_mclk or negedge i_rst_n) begin
	if (!i_rst_n)
		rd_word <= 16'h0000;
	else if (i_rd_valid)
		rd_word <= i_rd_data;
end

always @(posedge i_mclk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		state     <= ST_IDLE;
		ext       <= 1'b0;
		cnt       <= 5'h00;
		ocnt      <= 5'h00;
		rin       <= 16'h0000;
		sh        <= 16'h0000;
		addr      <= 9'h000;
		op        <= 8'h00;
		base_end  <= 1'b0;
		wen       <= 1'b0;
		prot      <= 2'h0;
		pend_cmd  <= `UFSPI_CMD_NONE;
		pend_addr <= 9'h000;
		pend_data <= 16'h0000;
		o_so      <= 1'b0;
		o_so_oe   <= 1'b0;
		o_rd_req  <= 1'b0;
		o_rd_addr <= 9'h000;
	end else begin
		o_rd_req <= 1'b0;
		if (cs_s) begin
			o_so_oe  <= 1'b0;
			state    <= ST_IDLE;
			pend_cmd <= `UFSPI_CMD_NONE;
		end else if (cs_fall) begin
			state    <= ST_OP;
			ext      <= ext_s;
			cnt      <= 5'h00;
			ocnt     <= 5'h00;
			base_end <= 1'b0;
		end else begin
			if (sck_rise && state != ST_IGNORE && state != ST_RDATA &&
				state != ST_STRD) begin
				rin <= word_in;
				cnt <= next_cnt;
				if (next_cnt == fw) begin
					cnt <= 5'h00;
					case (state)
					ST_OP: begin
						op    <= word_in[7:0];
						state <= ST_IGNORE;
						if (word_in[7:0] == `UFSPI_OP_WRITE_ENABLE)
							wen <= 1'b1;
						else if (word_in[7:0] == `UFSPI_OP_WRITE_DISABLE)
							wen <= 1'b0;
						else if (word_in[7:0] == `UFSPI_OP_READ_STATUS)
							state <= ST_STRD;
						else if (word_in[7:0] == `UFSPI_OP_WRITE_STATUS)
							state <= ST_STWR;
						else if (word_in[7:0] == `UFSPI_OP_FULL_ERASE) begin
							if (!busy)
								pend_cmd <= `UFSPI_CMD_FULL_ERASE;
						end else if ((word_in[7:0] == `UFSPI_OP_READ ||
							word_in[7:0] == `UFSPI_OP_WRITE ||
							word_in[7:0] == `UFSPI_OP_SECTOR_ERASE) && !busy)
							state <= ST_ADDR;
					end
					ST_ADDR: begin
						// low nine or eight address bits kept
						addr      <= addr_in;
						pend_addr <= addr_in;
						state     <= ST_IGNORE;
						if (op == `UFSPI_OP_READ) begin
							o_rd_req  <= 1'b1;
							o_rd_addr <= addr_in;
							state     <= ST_RDATA;
						end else if (op == `UFSPI_OP_WRITE)
							state <= ST_WDATA;
						else
							pend_cmd <= `UFSPI_CMD_SECTOR_ERASE;
					end
					ST_WDATA: begin
						pend_data <= ext ? word_in : {8'h00, word_in[7:0]};
						pend_cmd  <= `UFSPI_CMD_WRITE;
						state     <= ST_IGNORE;
					end
					ST_STWR: begin
						prot  <= word_in[`UFSPI_ST_PROT_HI:`UFSPI_ST_PROT_LO];
						state <= ST_IGNORE;
					end
					default: state <= ST_IGNORE;
					endcase
				end
			end
			if (sck_fall && (state == ST_RDATA || state == ST_STRD)) begin
				if (ocnt != 5'h00) begin
					o_so <= sh[15];
					sh   <= {sh[14:0], 1'b0};
					ocnt <= ocnt - 5'h01;
				end else if (state == ST_STRD) begin
					o_so    <= status[7];
					sh      <= {status[6:0], 9'h000};
					ocnt    <= `UFSPI_BYTE_W - 5'h01;
					o_so_oe <= 1'b1;
				end else if (base_end) begin
					o_so_oe <= 1'b0;
				end else begin
					o_so      <= rd_al[15];
					sh        <= {rd_al[14:0], 1'b0};
					ocnt      <= dw - 5'h01;
					o_so_oe   <= 1'b1;
					o_rd_req  <= 1'b1;
					o_rd_addr <= addr_inc;
					addr      <= addr_inc;
					if (!ext && addr == `UFSPI_BASE_LAST_ADDR) begin
						base_end <= 1'b1;
						o_rd_req <= 1'b0;
					end
				end
			end
		end
	end
end

// two-entry buffer toward the flash; refused commands never stall the link
always @(posedge i_mclk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		o_fl_valid <= 1'b0;
		o_fl_cmd   <= `UFSPI_CMD_NONE;
		o_fl_addr  <= 9'h000;
		o_fl_data  <= 16'h0000;
		sk_v       <= 1'b0;
		sk_cmd     <= `UFSPI_CMD_NONE;
		sk_addr    <= 9'h000;
		sk_data    <= 16'h0000;
	end else if (!o_fl_valid || fl_pop) begin
		if (sk_v) begin
			o_fl_valid <= 1'b1;
			o_fl_cmd   <= sk_cmd;
			o_fl_addr  <= sk_addr;
			o_fl_data  <= sk_data;
			sk_v       <= 1'b0;
		end else begin
			o_fl_valid <= push;
			o_fl_cmd   <= pend_cmd;
			o_fl_addr  <= pend_addr;
			o_fl_data  <= pend_data;
		end
	end else if (push) begin
		sk_v    <= 1'b1;
		sk_cmd  <= pend_cmd;
		sk_addr <= pend_addr;
		sk_data <= pend_data;
	end
end

endmodule

// ==== ufspi_defines.vh ====
`ifndef UFSPI_DEFINES_VH
`define UFSPI_DEFINES_VH

// opcodes, first byte after selection
`define UFSPI_OP_WRITE_ENABLE  8'h06
`define UFSPI_OP_WRITE_DISABLE 8'h04
`define UFSPI_OP_READ_STATUS   8'h05
`define UFSPI_OP_WRITE_STATUS  8'h01
`define UFSPI_OP_READ          8'h03
`define UFSPI_OP_WRITE         8'h02
`define UFSPI_OP_SECTOR_ERASE  8'h20
`define UFSPI_OP_FULL_ERASE    8'h60

// status register fields
`define UFSPI_ST_BUSY          0
`define UFSPI_ST_WEN           1
`define UFSPI_ST_PROT_LO       2
`define UFSPI_ST_PROT_HI       3
`define UFSPI_STATUS_RST       8'h00

// field widths in bits
`define UFSPI_BYTE_W           5'h08
`define UFSPI_BASE_W           5'h08
`define UFSPI_EXT_W            5'h10

// address limits
`define UFSPI_BASE_LAST_ADDR   9'h0ff
`define UFSPI_EXT_ADDR_MASK    9'h1ff

// flash command codes on the buffered port
`define UFSPI_CMD_NONE         2'h0
`define UFSPI_CMD_WRITE        2'h1
`define UFSPI_CMD_SECTOR_ERASE 2'h2
`define UFSPI_CMD_FULL_ERASE   2'h3

`endif

// ==== ufspi_monitor.sv ====
`timescale 1ns/1ps
module ufspi_monitor (
	input wire        i_mclk,              // system clock
	input wire        i_rst_n,             // async reset, active low
	input wire        i_sck,               // serial clock pin
	input wire        i_chip_select_n,     // chip select pin
	input wire        i_ext_mode,          // mode strap
	input wire        i_fl_ready,          // flash accepts command
	input wire        o_so,                // serial data out
	input wire        o_so_oe,             // serial out enable
	input wire        o_oscillator_enable, // oscillator on
	input wire        o_rd_req,            // read request pulse
	input wire [8:0]  o_rd_addr,           // read address
	input wire        o_fl_valid,          // command valid
	input wire [1:0]  o_fl_cmd,            // command code
	input wire [8:0]  o_fl_addr,           // command address
	input wire [15:0] o_fl_data            // write data
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	chk_osc_always_on: assert property (o_oscillator_enable)
		else $error("oscillator enable dropped");
	chk_so_on_fall: assert property ($changed(o_so) && o_so_oe
		|-> !i_sck && !$past(i_sck)) else $error("so moved in high phase");
	chk_oe_rise_sel: assert property ($rose(o_so_oe)
		|-> !i_sck && !i_chip_select_n) else $error("so driven badly");
	chk_desel_release: assert property (i_chip_select_n [*5]
		|-> !o_so_oe) else $error("so driven while deselected");
	chk_cmd_hold: assert property (o_fl_valid && !i_fl_ready
		|=> o_fl_valid && $stable({o_fl_cmd, o_fl_addr, o_fl_data}))
		else $error("flash command dropped");
	chk_rd_pulse: assert property (o_rd_req |=> !o_rd_req [*4])
		else $error("read request too long");
	chk_base_sector: assert property (o_rd_req && !i_ext_mode
		|-> !o_rd_addr[8]) else $error("base read left sector");
	chk_cmd_code: assert property (o_fl_valid |-> o_fl_cmd != 2'h0)
		else $error("empty flash command");
endmodule
bind ufspi_slave ufspi_monitor mon (
	.i_mclk              (i_mclk),
	.i_rst_n             (i_rst_n),
	.i_sck               (i_sck),
	.i_chip_select_n     (i_chip_select_n),
	.i_ext_mode          (i_ext_mode),
	.i_fl_ready          (i_fl_ready),
	.o_so                (o_so),
	.o_so_oe             (o_so_oe),
	.o_oscillator_enable (o_oscillator_enable),
	.o_rd_req            (o_rd_req),
	.o_rd_addr           (o_rd_addr),
	.o_fl_valid          (o_fl_valid),
	.o_fl_cmd            (o_fl_cmd),
	.o_fl_addr           (o_fl_addr),
	.o_fl_data           (o_fl_data)
);

// ==== ufspi_master.sv ====
`timescale 1ns/1ps
module ufspi_master (
	input  wire i_mclk,  // bench clock that paces the link
	output reg  o_sck,   // serial clock
	output reg  o_cs_n,  // chip select
	output reg  o_si,    // data to slave
	input  wire i_so,    // data from slave
	input  wire i_so_oe  // slave drives so
);
	reg  last;
	// released line shows no stale bit
	wire line = i_so_oe ? i_so : ~last;
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_si = 1'b0;
		last = 1'b0;
	end
	always @(posedge o_sck) last <= line;
	// low selects; edges land on bench clock edges
	task sel(input b);
		begin
			repeat (10) @(posedge i_mclk);
			o_cs_n <= b;
			repeat (10) @(posedge i_mclk);
		end
	endtask
	// msb first, master clocks; 8 cycles per half period
	task xfer(input [63:0] d, input integer n, output [63:0] r);
		integer k;
		begin
			r = 64'h0;
			for (k = n - 1; k >= 0; k = k - 1) begin
				o_si <= d[k];
				repeat (8) @(posedge i_mclk);
				o_sck <= 1'b1;
				r = {r[62:0], line};
				repeat (8) @(posedge i_mclk);
				o_sck <= 1'b0;
			end
		end
	endtask
endmodule

// ==== ufspi_slave_test.sv ====
`timescale 1ns/1ps
module ufspi_slave_test;
	reg         i_mclk = 0;
	reg         i_rst_n = 0;
	reg         ext = 1;
	reg  [15:0] rd_data = 16'h0000;
	reg         rd_valid = 0;
	reg         ready = 0;
	reg         busy = 0;
	wire        sck, cs_n, si, so, so_oe, osc, rd_req, fl_valid;
	wire [8:0]  rd_addr, fl_addr;
	wire [1:0]  fl_cmd;
	wire [15:0] fl_data;
	reg  [63:0] r;
	integer     n_mismatch = 0;
	integer     num_checks = 0;
	integer     n_rd = 0;
	integer     i;
	always #2 i_mclk = ~i_mclk;
	always @(posedge i_mclk) begin
		rd_valid <= rd_req;
		rd_data <= {~rd_addr[7:0], rd_addr[7:0]};
		if (rd_req)
			n_rd <= n_rd + 1;
	end
	ufspi_slave dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sck(sck),
		.i_chip_select_n(cs_n), .i_si(si), .i_ext_mode(ext),
		.i_rd_data(rd_data), .i_rd_valid(rd_valid), .i_fl_ready(ready),
		.i_fl_busy(busy), .o_so(so), .o_so_oe(so_oe),
		.o_oscillator_enable(osc), .o_rd_req(rd_req), .o_rd_addr(rd_addr),
		.o_fl_valid(fl_valid), .o_fl_cmd(fl_cmd), .o_fl_addr(fl_addr),
		.o_fl_data(fl_data));
	ufspi_master mst (.i_mclk(i_mclk), .o_sck(sck), .o_cs_n(cs_n),
		.o_si(si), .i_so(so), .i_so_oe(so_oe));
	task finish_test;
		begin
			$display("checks %0d mismatches %0d", num_checks, n_mismatch);
			if (n_mismatch == 0 && num_checks > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	task check(input string nm, input [31:0] seen, input [31:0] exp);
		begin
			num_checks = num_checks + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("mismatch %s exp %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task fr(input [63:0] d, input integer n);
		begin
			mst.sel(0);
			mst.xfer(d, n, r);
			mst.sel(1);
		end
	endtask
	// flash side stalls, then takes one command
	task take(input [1:0] cmd, input [8:0] a);
		begin
			for (i = 0; i < 100 && fl_valid !== 1'b1; i = i + 1)
				@(posedge i_mclk);
			if (i == 100) begin
				n_mismatch = n_mismatch + 1;
				finish_test;
			end
			repeat (5) @(posedge i_mclk);
			check("cmd", fl_cmd, cmd);
			check("addr", fl_addr, a);
			@(posedge i_mclk) ready <= 1'b1;
			@(posedge i_mclk) ready <= 1'b0;
		end
	endtask
	task t_status;
		begin
			fr(64'h0500, 16);
			check("status", r[7:0], 8'h00);
			fr(64'h06, 8);
			fr(64'h010c, 16);
			fr(64'h0500, 16);
			check("status", r[7:0], 8'h0e);
			fr(64'h0100, 16);
			fr(64'h04, 8);
			fr(64'h0500, 16);
			check("status", r[7:0], 8'h00);
			$display("test status done");
		end
	endtask
	task t_write;
		begin
			fr(64'h06, 8);
			fr({8'h02, 16'hfd55, 16'hbeef}, 40);
			fr(64'h0500, 16);
			check("status", r[7:0], 8'h03);
			check("data", fl_data, 16'hbeef);
			take(2'h1, 9'h155);
			fr({8'h20, 16'h0100}, 24);
			take(2'h2, 9'h100);
			fr(64'h60, 8);
			take(2'h3, 9'h100);
			$display("test write done");
		end
	endtask
	task t_read;
		begin
			fr({8'h03, 16'hfdff, 32'h0}, 56);
			check("wrap", r[31:0], 32'h00ffff00);
			@(posedge i_mclk) ext <= 1'b0;
			mst.sel(0);
			mst.xfer({8'h03, 8'hfe, 16'h0}, 32, r);
			check("base", r[15:0], 16'hfeff);
			repeat (8) @(posedge i_mclk);
			check("oe", so_oe, 1'b0);
			mst.sel(1);
			@(posedge i_mclk) ext <= 1'b1;
			$display("test read done");
		end
	endtask
	task t_ignore;
		begin
			i = n_rd;
			fr({8'h55, 8'h03, 16'h0000}, 32);
			mst.xfer({8'h03, 32'h0}, 40, r);
			check("reads", n_rd, i);
			check("oe", so_oe, 1'b0);
			$display("test ignore done");
		end
	endtask
	// busy refuses reads; full protection refuses write and erase
	task t_refuse;
		begin
			i = n_rd;
			@(posedge i_mclk) busy <= 1'b1;
			fr({8'h03, 16'h0010, 16'h0}, 40);
			check("reads", n_rd, i);
			fr(64'h0500, 16);
			check("status", r[7:0], 8'h03);
			@(posedge i_mclk) busy <= 1'b0;
			fr(64'h010c, 16);
			fr({8'h02, 16'h0000, 16'h1234}, 40);
			fr({8'h20, 16'h0000}, 24);
			repeat (8) @(posedge i_mclk);
			check("refused", fl_valid, 1'b0);
			fr(64'h0100, 16);
			$display("test refuse done");
		end
	endtask
	initial begin
		repeat (6) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		repeat (4) @(posedge i_mclk);
		check("osc", osc, 1'b1);
		t_status;
		t_write;
		t_read;
		t_ignore;
		t_refuse;
		finish_test;
	end
endmodule
